// file: sim/nmlp_keys.sv
`timescale 1ns/1ps
// Keys and sensors on the port; a line nobody drives falls to its pull-down.
module nmlp_keys (
    input  wire logic [3:0] k_out,
    input  wire logic [3:0] k_oe,
    input  wire logic [3:0] keys,
    input  wire logic       io_out,
    input  wire logic       io_oe,
    output logic      [3:0] k_in,
    output logic            io_in
);
    assign k_in  = (k_oe & k_out) | (~k_oe & keys);
    assign io_in = io_oe & io_out;
endmodule : nmlp_keys

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import nmlp_pkg::*;
    logic clk, rst, ext_init_n, instr_valid, instr_ready, io_in, io_out, io_oe, status;
    logic wake_rate_sel, current_source_on, char_msb_edge, io_wake_en;
    nmlp_op_t instr_op;
    logic [9:0] instr_code;
    nmlp_psel_t alu_p_sel;
    nmlp_nsel_t alu_n_sel;
    nmlp_fn_t alu_fn;
    nmlp_dst_t alu_dst;
    logic [3:0] time_slow, time_fast, k_in, k_out, k_oe, keys, acc, word_ptr, bank_ptr;
    logic [7:0] static_output_pins;
    logic [2:0] analog_sel;
    logic [15:0] exp_l;
    logic [3:0] acc_div;
    int errors, checks_done;
    wire [15:0] lat = {~io_wake_en, char_msb_edge, current_source_on, wake_rate_sel, analog_sel, k_oe[0],
                       static_output_pins};
    nmlp_core dut (.clk, .rst, .ext_init_n, .instr_valid, .instr_ready, .instr_op, .instr_code, .alu_p_sel,
        .alu_n_sel, .alu_fn, .alu_dst, .time_slow, .time_fast, .k_in, .k_out, .k_oe, .io_in, .io_out, .io_oe,
        .static_output_pins, .analog_sel, .wake_rate_sel, .current_source_on, .char_msb_edge, .io_wake_en,
        .acc, .word_ptr, .bank_ptr, .status);
    nmlp_keys far (.k_out, .k_oe, .keys, .io_out, .io_oe, .k_in, .io_in);
    // A second core with the top-line divider fitted, fed the same instructions and pins.
    nmlp_core #(.K8_DIV_OPT(1'b1)) dut_div (.clk, .rst, .ext_init_n, .instr_valid, .instr_ready(), .instr_op,
        .instr_code, .alu_p_sel, .alu_n_sel, .alu_fn, .alu_dst, .time_slow, .time_fast, .k_in, .k_out(), .k_oe(),
        .io_in, .io_out(), .io_oe(), .static_output_pins(), .analog_sel(), .wake_rate_sel(),
        .current_source_on(), .char_msb_edge(), .io_wake_en(), .acc(acc_div), .word_ptr(), .bank_ptr(),
        .status());
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Entered 1 ns after an edge; leaves 1 ns after the edge where results land.
    task automatic run(input nmlp_op_t op, input logic [9:0] code);
        instr_op = op;
        instr_code = code;
        instr_valid = 1'b1;
        @(posedge clk);
        #1 instr_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : run
    // Both operands come from the constant bus, so FN_ADD gives twice code[3:0], FN_SUB zero and FN_CMP code[3:0].
    task automatic alu(input nmlp_fn_t fn, input logic [9:0] code);
        alu_fn = fn;
        run(OP_ALU, code);
    endtask : alu
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    initial begin
        rst = 1'b1; ext_init_n = 1'b1; instr_valid = 1'b0; instr_op = OP_NOP; instr_code = 10'h000;
        alu_p_sel = P_CKB; alu_n_sel = N_CKB; alu_fn = FN_ADD; alu_dst = DST_ACC;
        time_slow = 4'h9; time_fast = 4'h6; keys = 4'h5; errors = 0; checks_done = 0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("latches", lat, 16'h0000);
        exp_l = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            run(OP_LOAD_WORD, 10'h040 + 10'(i));
            run(OP_LATCH_SET, 10'h000);
            exp_l[i] = 1'b1;
            chk("latch_set", lat, exp_l);
        end
        for (int i = 1; i < 16; i += 2) begin
            run(OP_LOAD_WORD, 10'h0C0 + 10'(i));
            run(OP_LATCH_CLEAR, 10'h000);
        end
        chk("latch_clear", lat, 16'h5555);
        run(OP_LOAD_WORD, 10'h018);
        chk("time_fast", word_ptr, 16'h6);
        $display("latch test done");
        ext_init_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 ext_init_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("init", lat, 16'h0000);
        run(OP_LOAD_WORD, 10'h01F);
        chk("time_slow", word_ptr, 16'h9);
        run(OP_LOAD_WORD, 10'h00C);
        chk("port_bus", word_ptr, 16'h5);
        run(OP_PORT_TO_ACC, 10'h000);
        chk("port_in", acc, 16'h5);
        keys = 4'hD;
        repeat (3) @(posedge clk);
        #1 keys = 4'h5;
        repeat (3) @(posedge clk);
        #1 run(OP_PORT_TO_ACC, 10'h000);
        chk("k8_half", acc_div, 16'hD);
        chk("k8_plain", acc, 16'h5);
        ext_init_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 ext_init_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 run(OP_PORT_TO_ACC, 10'h000);
        chk("k8_init", acc_div, 16'h5);
        alu(FN_ADD, 10'h045);
        run(OP_ACC_TO_PORT, 10'h000);
        chk("port_held", {k_oe, k_out}, 16'h0A);
        run(OP_LOAD_WORD, 10'h048);
        run(OP_LATCH_SET, 10'h000);
        chk("port_out", {k_oe, k_out}, 16'hFA);
        alu(FN_ADD, 10'h041);
        run(OP_PORT_TO_ACC, 10'h000);
        chk("port_back", acc, 16'hA);
        $display("port test done");
        run(OP_IO_HIGH, 10'h000);
        chk("io_high", {io_oe, io_out}, 16'h3);
        run(OP_IO_LOW, 10'h000);
        chk("io_low", {io_oe, io_out}, 16'h2);
        alu(FN_ADD, 10'h048);
        chk("carry", {status, acc}, 16'h10);
        run(OP_STATUS_TO_IO, 10'h000);
        chk("io_status", {io_oe, io_out}, 16'h3);
        run(OP_IO_INPUT, 10'h000);
        chk("io_input", io_oe, 16'h0);
        alu(FN_SUB, 10'h047);
        chk("sub", {status, acc}, 16'h10);
        alu(FN_ADD, 10'h045);
        alu_dst = DST_NONE;
        alu(FN_CMP, 10'h041);
        alu_dst = DST_ACC;
        chk("cmp", {status, acc}, 16'h0A);
        $display("io and alu test done");
        run(OP_LOAD_BANK, 10'h047);
        run(OP_LOAD_WORD, 10'h043);
        run(OP_ACC_TO_MEM, 10'h000);
        run(OP_LOAD_BANK, 10'h040);
        alu(FN_ADD, 10'h043);
        run(OP_ACC_TO_MEM, 10'h000);
        run(OP_LOAD_BANK, 10'h04F);
        run(OP_MEM_TO_ACC, 10'h000);
        chk("shared", acc, 16'hA);
        run(OP_BANK_MEM_ADD, 10'h000);
        chk("double", {status, acc}, 16'h14);
        $display("memory test done");
        finish_test();
    end
endmodule : testbench

// file: src/nmlp_core.sv
`timescale 1ns/1ps
`include "nmlp_defs.svh"

module nmlp_core #(
    parameter bit K8_DIV_OPT = 1'h0
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ext_init_n,
    input  wire logic                instr_valid,
    output logic                     instr_ready,
    input  wire nmlp_pkg::nmlp_op_t  instr_op,
    input  wire logic [9:0]          instr_code,
    input  wire nmlp_pkg::nmlp_psel_t alu_p_sel,
    input  wire nmlp_pkg::nmlp_nsel_t alu_n_sel,
    input  wire nmlp_pkg::nmlp_fn_t  alu_fn,
    input  wire nmlp_pkg::nmlp_dst_t alu_dst,
    input  wire logic [3:0]          time_slow,
    input  wire logic [3:0]          time_fast,
    input  wire logic [3:0]          k_in,
    output logic      [3:0]          k_out,
    output logic      [3:0]          k_oe,
    input  wire logic                io_in,
    output logic                     io_out,
    output logic                     io_oe,
    output logic      [7:0]          static_output_pins,
    output logic      [2:0]          analog_sel,
    output logic                     wake_rate_sel,
    output logic                     current_source_on,
    output logic                     char_msb_edge,
    output logic                     io_wake_en,
    output logic      [3:0]          acc,
    output logic      [3:0]          word_ptr,
    output logic      [3:0]          bank_ptr,
    output logic                     status
);
    import nmlp_pkg::*;

    nmlp_state_t st_r, st_nxt;
    nmlp_op_t    op_r, op_nxt;
    nmlp_psel_t  p_r, p_nxt;
    nmlp_nsel_t  n_r, n_nxt;
    nmlp_fn_t    fn_r, fn_nxt;
    nmlp_dst_t   dst_r, dst_nxt;
    logic [9:0]  code_r, code_nxt;
    logic [3:0]  acc_r, acc_nxt, wp_r, wp_nxt, bp_r, bp_nxt, kreg_r, kreg_nxt;
    logic        flag_r, flag_nxt, io_oe_r, io_oe_nxt, io_out_r, io_out_nxt;
    logic [15:0] latch_r, latch_nxt;
    logic        k8_div_r, k8_div_nxt, k8_prev_r;
    logic [5:0]  sync_q;
    logic [3:0]  k_s, kval, constant_bus, ram_q, dam_q, mem_q, p_val, n_val, ram_bank, mem_wd;
    logic        io_s, init_s, exec, dam_sel, mem_we, alu_flag;
    logic [4:0]  alu_sum;

    // ------------------------------------------------------------------------
    // Pin inputs and memory
    // ------------------------------------------------------------------------
    nmlp_sync #(.W(6)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({ext_init_n, io_in, k_in}),
        .q   (sync_q)
    );
    assign k_s    = sync_q[3:0];
    assign io_s   = sync_q[4];
    assign init_s = ~sync_q[5];
    assign exec   = (st_r == ST_EXEC);

    // Banks 8-E fold onto RAM rows 7-13, so no row is wasted on 7 or F.
    assign dam_sel  = (bp_r[2:0] == `NMLP_DAM_BANK_LOW);
    assign ram_bank = bp_r[3] ? ({1'h0, bp_r[2:0]} + `NMLP_UPPER_BANK_OFS) : {1'h0, bp_r[2:0]};

    nmlp_mem #(.DEPTH(`NMLP_RAM_DEPTH), .AW(`NMLP_RAM_AW)) u_ram (
        .clk   (clk),
        .rst   (rst),
        .we    (mem_we & ~dam_sel),
        .waddr ({ram_bank, wp_r}),
        .wdata (mem_wd),
        .raddr ({ram_bank, wp_r}),
        .rdata (ram_q)
    );

    nmlp_mem #(.DEPTH(`NMLP_DAM_DEPTH), .AW(`NMLP_DAM_AW)) u_dam (
        .clk   (clk),
        .rst   (rst),
        .we    (mem_we & dam_sel),
        .waddr (wp_r),
        .wdata (mem_wd),
        .raddr (wp_r),
        .rdata (dam_q)
    );
    assign mem_q = dam_sel ? dam_q : ram_q;

    // ------------------------------------------------------------------------
    // Port read path and constant bus
    // ------------------------------------------------------------------------
    assign kval = {(K8_DIV_OPT ? k8_div_r : k_s[3]), k_s[2:0]};

    always_comb begin
        constant_bus = 4'h0;
        if (code_r >= `NMLP_OPC_K_LO && code_r <= `NMLP_OPC_K_HI) begin
            constant_bus = kval;
        end else if (code_r >= `NMLP_OPC_TIME_LO && code_r <= `NMLP_OPC_TIME_HI) begin
            constant_bus = latch_r[`NMLP_DL_WAKE_RATE] ? time_fast : time_slow;
        end else if ((code_r >= `NMLP_OPC_BITA_LO && code_r <= `NMLP_OPC_BITA_HI) ||
                     (code_r >= `NMLP_OPC_BITB_LO && code_r <= `NMLP_OPC_BITB_HI)) begin
            constant_bus = 4'h1 << code_r[1:0];
        end else if ((code_r >= `NMLP_OPC_CONA_LO && code_r <= `NMLP_OPC_CONA_HI) ||
                     (code_r >= `NMLP_OPC_CONB_LO && code_r <= `NMLP_OPC_CONB_HI)) begin
            constant_bus = code_r[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------------------
    always_comb begin
        case (p_r)
            P_WORD:  p_val = wp_r;
            P_DAM:   p_val = dam_q;
            P_CKB:   p_val = constant_bus;
            default: p_val = mem_q;
        endcase
        case (n_r)
            N_CKB:   n_val = constant_bus;
            N_ACC:   n_val = acc_r;
            default: n_val = mem_q;
        endcase
        case (fn_r)
            FN_ADD:  alu_sum = {1'h0, p_val} + {1'h0, n_val};
            FN_SUB:  alu_sum = {1'h0, n_val} + {1'h0, ~p_val} + 5'h01;
            default: alu_sum = {1'h0, n_val};
        endcase
        alu_flag = (fn_r == FN_CMP) ? (p_val != n_val) : alu_sum[4];
    end

    // ------------------------------------------------------------------------
    // Memory write data
    // ------------------------------------------------------------------------
    always_comb begin
        mem_we = 1'h0;
        mem_wd = acc_r;
        if (exec) begin
            case (op_r)
                OP_ACC_TO_MEM: mem_we = 1'h1;
                OP_PORT_TO_MEM: begin
                    mem_we = 1'h1;
                    mem_wd = kval;
                end
                OP_BIT_SET: begin
                    mem_we = 1'h1;
                    mem_wd = mem_q | constant_bus;
                end
                OP_BIT_CLEAR: begin
                    mem_we = 1'h1;
                    mem_wd = mem_q & ~constant_bus;
                end
                default: mem_we = 1'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer and processor registers
    // ------------------------------------------------------------------------
    // Memory reads are registered, so each instruction takes an idle cycle
    // to address the word and an execute cycle to use it.
    always_comb begin
        st_nxt     = st_r;
        op_nxt     = op_r;
        p_nxt      = p_r;
        n_nxt      = n_r;
        fn_nxt     = fn_r;
        dst_nxt    = dst_r;
        code_nxt   = code_r;
        acc_nxt    = acc_r;
        wp_nxt     = wp_r;
        bp_nxt     = bp_r;
        kreg_nxt   = kreg_r;
        flag_nxt   = flag_r;
        io_oe_nxt  = io_oe_r;
        io_out_nxt = io_out_r;
        if (!exec) begin
            if (instr_valid) begin
                st_nxt   = ST_EXEC;
                op_nxt   = instr_op;
                p_nxt    = alu_p_sel;
                n_nxt    = alu_n_sel;
                fn_nxt   = alu_fn;
                dst_nxt  = alu_dst;
                code_nxt = instr_code;
            end
        end else begin
            st_nxt = ST_IDLE;
            case (op_r)
                OP_ALU: begin
                    flag_nxt = alu_flag;
                    if (dst_r == DST_ACC) begin
                        acc_nxt = alu_sum[3:0];
                    end else if (dst_r == DST_WORD) begin
                        wp_nxt = alu_sum[3:0];
                    end
                end
                OP_LOAD_BANK:     bp_nxt = constant_bus;
                OP_TRANSFER_BANK: bp_nxt = acc_r;
                OP_FLIP_BANK_MSB: bp_nxt = {~bp_r[3], bp_r[2:0]};
                OP_LOAD_WORD:     wp_nxt = constant_bus;
                OP_BANK_MEM_ADD:  {flag_nxt, acc_nxt} = {1'h0, dam_q} + {1'h0, mem_q};
                OP_MEM_TO_ACC:    acc_nxt = mem_q;
                OP_ACC_TO_PORT:   kreg_nxt = acc_r;
                OP_PORT_TO_ACC:   acc_nxt = kval;
                OP_PORT_NZ_TEST:  flag_nxt = |kval;
                OP_IO_INPUT:      io_oe_nxt = 1'h0;
                OP_IO_HIGH: begin
                    io_oe_nxt  = 1'h1;
                    io_out_nxt = 1'h1;
                end
                OP_IO_LOW: begin
                    io_oe_nxt  = 1'h1;
                    io_out_nxt = 1'h0;
                end
                OP_STATUS_TO_IO: begin
                    io_oe_nxt  = 1'h1;
                    io_out_nxt = flag_r;
                end
                OP_BIT_TEST:      flag_nxt = |(mem_q & constant_bus);
                default:          flag_nxt = flag_r;
            endcase
        end
        if (init_s) begin
            io_oe_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r     <= ST_IDLE;
            op_r     <= OP_NOP;
            p_r      <= P_WORD;
            n_r      <= N_CKB;
            fn_r     <= FN_ADD;
            dst_r    <= DST_NONE;
            code_r   <= 10'h000;
            acc_r    <= `NMLP_NIB_RST;
            wp_r     <= `NMLP_NIB_RST;
            bp_r     <= `NMLP_NIB_RST;
            kreg_r   <= `NMLP_NIB_RST;
            flag_r   <= 1'h0;
            io_oe_r  <= 1'h0;
            io_out_r <= 1'h0;
        end else begin
            st_r     <= st_nxt;
            op_r     <= op_nxt;
            p_r      <= p_nxt;
            n_r      <= n_nxt;
            fn_r     <= fn_nxt;
            dst_r    <= dst_nxt;
            code_r   <= code_nxt;
            acc_r    <= acc_nxt;
            wp_r     <= wp_nxt;
            bp_r     <= bp_nxt;
            kreg_r   <= kreg_nxt;
            flag_r   <= flag_nxt;
            io_oe_r  <= io_oe_nxt;
            io_out_r <= io_out_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Digit latches and top-line divider
    // ------------------------------------------------------------------------
    // Only instructions, init and reset touch the latches; while no instruction
    // executes and init is released, the latches keep their values.
    for (genvar gi = 0; gi < 16; gi++) begin : g_latch
        assign latch_nxt[gi] = init_s ? 1'h0 :
            (exec && wp_r == 4'(gi) && op_r == OP_LATCH_SET)   ? 1'h1 :
            (exec && wp_r == 4'(gi) && op_r == OP_LATCH_CLEAR) ? 1'h0 :
            latch_r[gi];
    end

    assign k8_div_nxt = init_s ? 1'h0 : (k_s[3] & ~k8_prev_r) ? ~k8_div_r : k8_div_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_r   <= `NMLP_LATCH_RST;
            k8_div_r  <= 1'h0;
            k8_prev_r <= 1'h0;
        end else begin
            latch_r   <= latch_nxt;
            k8_div_r  <= k8_div_nxt;
            k8_prev_r <= k_s[3];
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign instr_ready        = (st_r == ST_IDLE);
    assign static_output_pins = latch_r[`NMLP_DL_STATIC_HI:0];
    assign k_oe               = {4{latch_r[`NMLP_DL_PORT_DIR]}};
    assign k_out              = kreg_r;
    assign analog_sel         = latch_r[`NMLP_DL_ANALOG_HI:`NMLP_DL_ANALOG_LO];
    assign wake_rate_sel      = latch_r[`NMLP_DL_WAKE_RATE];
    assign current_source_on  = latch_r[`NMLP_DL_CURRENT];
    assign char_msb_edge      = latch_r[`NMLP_DL_CHAR_EDGE];
    assign io_wake_en         = ~latch_r[`NMLP_DL_IO_BLOCK];
    assign io_out             = io_out_r;
    assign io_oe              = io_oe_r;
    assign acc                = acc_r;
    assign word_ptr           = wp_r;
    assign bank_ptr           = bp_r;
    assign status             = flag_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    latch_set_a: assert property (@(posedge clk) disable iff (rst)
        exec && op_r == OP_LATCH_SET && !init_s |=> latch_r[$past(wp_r)])
        else $error("latch set did not take effect");
    init_clear_a: assert property (@(posedge clk) disable iff (rst)
        init_s |=> latch_r == 16'h0000 && !io_oe)
        else $error("init did not clear latches");
    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        !exec && !init_s |=> $stable(latch_r))
        else $error("latches changed without instruction");
    port_drive_a: assert property (@(posedge clk) disable iff (rst)
        exec && op_r == OP_ACC_TO_PORT |=> k_out == $past(acc_r) ##1 k_out == $past(acc_r, 2))
        else $error("port register not loaded from accumulator");
    dam_guard_a: assert property (@(posedge clk) disable iff (rst)
        mem_we && !(bp_r == 4'h7 || bp_r == 4'hF) |-> u_dam.we == 1'h0)
        else $error("shared bank written outside banks 7 and F");
    dam_double_a: assert property (@(posedge clk) disable iff (rst)
        exec && op_r == OP_BANK_MEM_ADD && dam_sel |=> acc_r == 4'($past(dam_q) << 1))
        else $error("bank plus memory did not double");
    io_input_a: assert property (@(posedge clk) disable iff (rst)
        exec && op_r == OP_IO_INPUT |=> !io_oe)
        else $error("I/O pin not returned to input");
    io_drive_a: assert property (@(posedge clk) disable iff (rst)
        exec && op_r == OP_STATUS_TO_IO && !init_s |=> io_oe && io_out == $past(flag_r))
        else $error("I/O pin not driving status");
    ckb_port_a: assert property (@(posedge clk) disable iff (rst)
        exec && code_r >= 10'h008 && code_r <= 10'h00F |-> constant_bus == kval)
        else $error("constant bus not carrying port lines");
    instr_cycle_a: assert property (@(posedge clk) disable iff (rst)
        instr_valid && instr_ready |=> !instr_ready ##1 instr_ready)
        else $error("instruction did not take two cycles");

endmodule : nmlp_core

// file: src/nmlp_defs.svh
`ifndef NMLP_DEFS_SVH
`define NMLP_DEFS_SVH

// ----------------------------------------------------------------------------
// Digit latch positions
// ----------------------------------------------------------------------------
`define NMLP_DL_STATIC_HI   7
`define NMLP_DL_PORT_DIR    8
`define NMLP_DL_ANALOG_LO   9
`define NMLP_DL_ANALOG_HI   11
`define NMLP_DL_WAKE_RATE   12
`define NMLP_DL_CURRENT     13
`define NMLP_DL_CHAR_EDGE   14
`define NMLP_DL_IO_BLOCK    15

// ----------------------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------------------
`define NMLP_RAM_DEPTH      224
`define NMLP_RAM_AW         8
`define NMLP_DAM_DEPTH      16
`define NMLP_DAM_AW         4
`define NMLP_DAM_BANK_LOW   3'h7
`define NMLP_UPPER_BANK_OFS 4'h7

// ----------------------------------------------------------------------------
// Constant bus source ranges in the opcode map
// ----------------------------------------------------------------------------
`define NMLP_OPC_K_LO       10'h008
`define NMLP_OPC_K_HI       10'h00F
`define NMLP_OPC_TIME_LO    10'h018
`define NMLP_OPC_TIME_HI    10'h01F
`define NMLP_OPC_BITA_LO    10'h020
`define NMLP_OPC_BITA_HI    10'h02F
`define NMLP_OPC_BITB_LO    10'h0A0
`define NMLP_OPC_BITB_HI    10'h0AF
`define NMLP_OPC_CONA_LO    10'h040
`define NMLP_OPC_CONA_HI    10'h07F
`define NMLP_OPC_CONB_LO    10'h0C0
`define NMLP_OPC_CONB_HI    10'h0FF

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define NMLP_LATCH_RST      16'h0000
`define NMLP_NIB_RST        4'h0

`endif

// file: src/nmlp_mem.sv
`timescale 1ns/1ps

module nmlp_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [3:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [3:0]    rdata
);

    logic [3:0] mem_r [DEPTH];

    // ------------------------------------------------------------------------
    // Contents are never cleared: they survive reset like the real cells.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 4'h0;
        end else begin
            rdata <= mem_r[raddr];
        end
    end

endmodule : nmlp_mem

// file: src/nmlp_pkg.sv
package nmlp_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_EXEC = 1'h1
    } nmlp_state_t;

    typedef enum logic [4:0] {
        OP_NOP           = 5'h00,
        OP_ALU           = 5'h01,
        OP_LOAD_BANK     = 5'h02,
        OP_TRANSFER_BANK = 5'h03,
        OP_FLIP_BANK_MSB = 5'h04,
        OP_LOAD_WORD     = 5'h05,
        OP_LATCH_SET     = 5'h06,
        OP_LATCH_CLEAR   = 5'h07,
        OP_BANK_MEM_ADD  = 5'h08,
        OP_MEM_TO_ACC    = 5'h09,
        OP_ACC_TO_MEM    = 5'h0A,
        OP_ACC_TO_PORT   = 5'h0B,
        OP_PORT_TO_ACC   = 5'h0C,
        OP_PORT_TO_MEM   = 5'h0D,
        OP_PORT_NZ_TEST  = 5'h0E,
        OP_IO_INPUT      = 5'h0F,
        OP_IO_HIGH       = 5'h10,
        OP_IO_LOW        = 5'h11,
        OP_STATUS_TO_IO  = 5'h12,
        OP_BIT_SET       = 5'h13,
        OP_BIT_CLEAR     = 5'h14,
        OP_BIT_TEST      = 5'h15
    } nmlp_op_t;

    typedef enum logic [1:0] {
        P_WORD = 2'h0,
        P_DAM  = 2'h1,
        P_CKB  = 2'h2,
        P_MEM  = 2'h3
    } nmlp_psel_t;

    typedef enum logic [1:0] {
        N_CKB = 2'h0,
        N_ACC = 2'h1,
        N_MEM = 2'h2
    } nmlp_nsel_t;

    typedef enum logic [1:0] {
        FN_ADD = 2'h0,
        FN_SUB = 2'h1,
        FN_CMP = 2'h2
    } nmlp_fn_t;

    typedef enum logic [1:0] {
        DST_NONE = 2'h0,
        DST_ACC  = 2'h1,
        DST_WORD = 2'h2
    } nmlp_dst_t;

endpackage : nmlp_pkg

// file: src/nmlp_sync.sv
`timescale 1ns/1ps

module nmlp_sync #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ------------------------------------------------------------------------
    // Two-stage synchroniser; only the second stage leaves this module.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : nmlp_sync
